/* pio_bit_port.sv */
`timescale 1ns/1ns
module pio_bit_port
  import pio_bit_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic                          ctrl_wr,
  input  wire logic [7:0]                    ctrl_data,
  input  wire logic [pio_bit_pkg::PORT_W-1:0] port_in,
  input  wire logic [pio_bit_pkg::PORT_W-1:0] out_data,
  output logic      [pio_bit_pkg::PORT_W-1:0] port_out,
  output logic      [pio_bit_pkg::PORT_W-1:0] port_oe_n,
  output logic      [pio_bit_pkg::PORT_W-1:0] in_data,
  output logic      [1:0]                    mode,
  output logic                               irq_pending,
  output logic                               irq
);
  import pio_bit_pkg::*;

  logic [PORT_W-1:0] sync1_reg;
  logic [PORT_W-1:0] sync2_reg;
  logic [PORT_W-1:0] dir_reg;
  logic [PORT_W-1:0] mask_reg;
  logic [PORT_W-1:0] out_reg;
  logic [1:0]        mode_reg;
  logic              func_and_reg;
  logic              lvl_high_reg;
  logic              ien_reg;
  logic              pend_reg;
  logic              cond_reg;
  expect_t           exp_reg;
  // decode and evaluation helpers
  logic              is_mode;
  logic              is_icw;
  logic              is_ien;
  logic [PORT_W-1:0] active;
  logic [PORT_W-1:0] considered;
  logic              cond_now;
  logic [1:0]        mode_sel;
  logic              pend_set;
  logic              pend_clr;

  // word classification; a pending data word takes precedence
  // pattern decode
  always_comb
  begin
    is_mode = (exp_reg == EXP_ANY) &&
              ((ctrl_data[3:0] & MODE_LOW_MASK) == MODE_LOW_PAT);
    is_icw  = (exp_reg == EXP_ANY) &&
              ((ctrl_data[3:0] & ICW_LOW_MASK) == ICW_LOW_PAT);
    is_ien  = (exp_reg == EXP_ANY) &&
              ((ctrl_data[3:0] & IEN_LOW_MASK) == IEN_LOW_PAT);
  end

  // mode field of a mode word, used only when the word is a mode word
  assign mode_sel = ctrl_data[MODE_HI_BIT:MODE_LO_BIT];

  // two-stage synchroniser for the port pins
  // nothing but the second stage reads the first
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= port_in;
      sync2_reg <= sync1_reg;
    end
  end

  // expected next word sequencing; a data word is never decoded
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      exp_reg <= EXP_ANY;
    else if (ctrl_wr)
    begin
      case (exp_reg)
        EXP_ANY:
        begin
          if (is_mode && mode_sel == MODE_BIT_CTRL)
            exp_reg <= EXP_DIR;
          else if (is_icw && ctrl_data[ICW_MASK_BIT])
            exp_reg <= EXP_MASK;
          else
            exp_reg <= EXP_ANY;
        end
        // the data word has been taken; decode resumes
        EXP_DIR:
          exp_reg <= EXP_ANY;
        EXP_MASK:
          exp_reg <= EXP_ANY;
        default:
          exp_reg <= EXP_ANY;
      endcase
    end
  end

  // mode register
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mode_reg <= MODE_RST;
    else if (ctrl_wr && is_mode)
      mode_reg <= mode_sel;
  end

  // direction and mask registers
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dir_reg  <= DIR_RST;
      mask_reg <= MASK_RST;
    end
    else if (ctrl_wr && exp_reg == EXP_DIR)
      dir_reg <= ctrl_data;
    else if (ctrl_wr && exp_reg == EXP_MASK)
      mask_reg <= ctrl_data;
  end

  // interrupt function, level and enable
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      func_and_reg <= 1'b0;
      lvl_high_reg <= 1'b0;
      ien_reg      <= 1'b0;
    end
    else if (ctrl_wr && is_icw)
    begin
      func_and_reg <= ctrl_data[ICW_FUNC_BIT];
      lvl_high_reg <= ctrl_data[ICW_LVL_BIT];
      ien_reg      <= ctrl_data[ICW_EN_BIT];
    end
    else if (ctrl_wr && is_ien)
      ien_reg <= ctrl_data[IEN_EN_BIT];
  end

  // output latch, taken every cycle for all lines
  // lines set as inputs ignore it at the pin, but it is still latched
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      out_reg <= '0;
    else
      out_reg <= out_data;
  end

  // evaluate the logic function over considered inputs
  // masked lines dropped
  always_comb
  begin
    active     = lvl_high_reg ? sync2_reg : ~sync2_reg;
    considered = dir_reg & ~mask_reg;
    // an empty set of considered lines would make AND true at once,
    // so it is held off explicitly
    // AND all, OR any
    if (considered == '0)
      cond_now = 1'b0;
    else if (func_and_reg)
      cond_now = ((active | ~considered) == '1);
    else
      cond_now = ((active & considered) != '0);
  end

  // a rising condition sets the flag only in bit mode with irq enabled
  // level-driven rising condition
  assign pend_set = (mode_reg == MODE_BIT_CTRL) && ien_reg &&
                    cond_now && !cond_reg;
  // clear on D4, in any mode
  assign pend_clr = ctrl_wr && is_icw && ctrl_data[ICW_MASK_BIT];

  // pending flag: set on condition becoming true, set wins over clear
  // cond_reg follows even while disabled, so enabling never fires on a
  // condition that was already true
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cond_reg <= 1'b0;
      pend_reg <= 1'b0;
    end
    else
    begin
      cond_reg <= cond_now;
      if (pend_set)
        pend_reg <= 1'b1;
      else if (pend_clr)
        pend_reg <= 1'b0;
    end
  end

  assign port_oe_n   = dir_reg;
  assign port_out    = out_reg;
  assign in_data     = sync2_reg;
  assign mode        = mode_reg;
  assign irq_pending = pend_reg;
  // irq follows the enable at once, so a disable word silences it
  assign irq         = pend_reg & ien_reg;
endmodule

/* pio_bit_pkg.sv */
package pio_bit_pkg;
  localparam int PORT_W = 8;
  // control word recognition patterns in the low-order bits
  localparam logic [3:0] MODE_LOW_MASK   = 4'hF;
  localparam logic [3:0] MODE_LOW_PAT    = 4'hF;
  localparam logic [3:0] ICW_LOW_MASK    = 4'hF;
  localparam logic [3:0] ICW_LOW_PAT     = 4'h7;
  localparam logic [3:0] IEN_LOW_MASK    = 4'hF;
  localparam logic [3:0] IEN_LOW_PAT     = 4'h3;
  // field positions
  localparam int MODE_HI_BIT  = 7;
  localparam int MODE_LO_BIT  = 6;
  localparam int ICW_EN_BIT   = 7;
  localparam int ICW_FUNC_BIT = 6;
  localparam int ICW_LVL_BIT  = 5;
  localparam int ICW_MASK_BIT = 4;
  localparam int IEN_EN_BIT   = 7;
  // mode codes
  localparam logic [1:0] MODE_BIT_CTRL = 2'h3;
  // reset values
  localparam logic [1:0] MODE_RST = 2'h1;
  localparam logic [7:0] DIR_RST  = 8'hFF;
  localparam logic [7:0] MASK_RST = 8'h00;
  typedef enum logic [1:0]
  {
    EXP_ANY  = 2'b00,
    EXP_DIR  = 2'b01,
    EXP_MASK = 2'b10
  } expect_t;
endpackage

/* pio_pins_model.sv */
`timescale 1ns/1ns
module pio_pins_model
(
  input  wire logic [7:0] ext,
  input  wire logic [7:0] port_out,
  input  wire logic [7:0] port_oe_n,
  output logic      [7:0] pin
);
  assign pin = (port_out & ~port_oe_n) | (ext & port_oe_n);
endmodule

/* pio_bit_port_monitor.sv */
`timescale 1ns/1ns
module pio_bit_port_monitor
(
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       ctrl_wr,
  input wire logic [7:0] ctrl_data,
  input wire logic [7:0] port_oe_n,
  input wire logic [1:0] mode,
  input wire logic       irq_pending,
  input wire logic       irq
);
  logic exp_reg;
  wire  cw = ctrl_wr && !exp_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // tracks a pending data word
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      exp_reg <= 1'b0;
    else if (ctrl_wr)
      exp_reg <= cw && ((ctrl_data[7:6] == 2'h3 && ctrl_data[3:0] == 4'hF) ||
                        ctrl_data[4:0] == 5'h17);
  sequence s_m3;
    cw && ctrl_data[7:6] == 2'h3 && ctrl_data[3:0] == 4'hF;
  endsequence
  sequence s_icw4;
    cw && ctrl_data[4:0] == 5'h17;
  endsequence
  mode_load_a: assert property (cw && ctrl_data[3:0] == 4'hF |=>
    mode == $past(ctrl_data[7:6])) else $error("mode");
  dir_load_a: assert property (s_m3 ##1 ctrl_wr |=>
    port_oe_n == $past(ctrl_data)) else $error("dir");
  mask_word_a: assert property (s_icw4 ##1 ctrl_wr |=>
    $stable(mode) && $stable(port_oe_n)) else $error("mask");
  pend_clr_a: assert property (s_icw4 and mode != 2'h3
    |=> !irq_pending) else $error("clear");
  no_set_a: assert property (!irq_pending && mode != 2'h3
    ##1 mode != 2'h3 |-> !irq_pending) else $error("set");
  en_word_a: assert property (cw && ctrl_data[3:0] == 4'h3 |=>
    irq == (irq_pending && $past(ctrl_data[7]))) else $error("en");
  irq_gate_a: assert property (irq |-> irq_pending)
    else $error("gate");
  bad_word_a: assert property (cw && ctrl_data[1:0] != 2'h3 |=>
    $stable(mode) && $stable(port_oe_n)) else $error("bad");
endmodule

/* tb.sv */
`timescale 1ns/1ns
module tb;
  import pio_bit_pkg::*;
  logic       clk, reset_n, ctrl_wr, irq_pending, irq;
  logic [7:0] ctrl_data, out_data, ext, pin, port_out, port_oe_n, in_data;
  logic [1:0] mode;
  int         fail_count, check_count, cyc;
  pio_bit_port i_dut (.clk, .reset_n, .ctrl_wr, .ctrl_data, .port_in(pin),
    .out_data, .port_out, .port_oe_n, .in_data, .mode, .irq_pending, .irq);
  pio_pins_model i_pins (.ext, .port_out, .port_oe_n, .pin);
  // clock and hang limit
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 500)
    begin
      fail_count++;
      report_and_stop;
    end
  end
  task wr(input logic [7:0] d);
    @(posedge clk);
    ctrl_wr   <= 1'b1;
    ctrl_data <= d;
  endtask
  // ends the burst, sets far side, settles
  task go(input logic [7:0] v, input int n);
    @(posedge clk);
    ctrl_wr <= 1'b0;
    ext     <= v;
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("FAIL %s expected %h seen %h", s, e, g);
      fail_count++;
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // word sequences with expected port state
  initial
  begin
    {reset_n, ctrl_wr, ctrl_data, out_data, ext} <= '0;
    repeat (4) @(posedge clk);
    reset_n  <= 1'b1;
    out_data <= 8'h05;
    go(8'h00, 0);
    chk("mode", {6'h0, MODE_RST}, {6'h0, mode});
    chk("dir", DIR_RST, port_oe_n);
    wr(8'hCF);
    wr(8'hF0);
    go(8'h00, 4);
    chk("mode", 8'h03, {6'h0, mode});
    chk("dir", 8'hF0, port_oe_n);
    chk("in", 8'h05, in_data);
    chk("out", 8'h05, port_out);
    wr(8'hB7);
    wr(8'h1F);
    go(8'h10, 5);
    chk("irq", 8'h00, {7'h0, irq});
    go(8'h30, 5);
    chk("irq", 8'h01, {7'h0, irq});
    wr(8'h03);
    go(8'h30, 1);
    chk("irq", 8'h00, {7'h0, irq});
    chk("pend", 8'h01, {7'h0, irq_pending});
    wr(8'h83);
    go(8'h30, 1);
    chk("irq", 8'h01, {7'h0, irq});
    wr(8'hD7);
    wr(8'h0F);
    go(8'h20, 5);
    chk("pend", 8'h00, {7'h0, irq_pending});
    go(8'h00, 5);
    chk("irq", 8'h01, {7'h0, irq});
    wr(8'h0F);
    go(8'h00, 1);
    chk("pend", 8'h01, {7'h0, irq_pending});
    wr(8'h17);
    wr(8'hCF);
    wr(8'hC1);
    go(8'h00, 1);
    chk("pend", 8'h00, {7'h0, irq_pending});
    chk("mode", 8'h00, {6'h0, mode});
    chk("dir", 8'hF0, port_oe_n);
    // reset in mid-run returns the port to its idle setup
    @(posedge clk);
    reset_n <= 1'b0;
    go(8'h00, 1);
    chk("rst mode", {6'h0, MODE_RST}, {6'h0, mode});
    chk("rst dir", DIR_RST, port_oe_n);
    chk("rst out", 8'h00, port_out);
    chk("rst in", 8'h00, in_data);
    chk("rst irq", 8'h00, {7'h0, irq});
    @(posedge clk);
    reset_n <= 1'b1;
    go(8'hA0, 3);
    chk("out", 8'h05, port_out);
    chk("in", 8'hA0, in_data);
    report_and_stop;
  end
endmodule
bind pio_bit_port pio_bit_port_monitor i_mon (.clk, .reset_n, .ctrl_wr,
  .ctrl_data, .port_oe_n, .mode, .irq_pending, .irq);
